// File: pkg/sac_pkg.sv
`default_nettype none
package sac_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] SAC_RES_LO_ADDR = 8'hBE;
  localparam logic [7:0] SAC_RES_HI_ADDR = 8'hBF;
  localparam logic [7:0] SAC_CTRL_ADDR = 8'hE8;

  // Reset values.
  localparam logic [7:0] SAC_CTRL_RST = 8'h00;
  localparam logic [7:0] SAC_RES_RST = 8'h00;
  localparam logic [4:0] SAC_DIV_RST = 5'h1F;

  // Field positions inside converter_control.
  localparam int unsigned SAC_EN_BIT = 7;
  localparam int unsigned SAC_TM_BIT = 6;
  localparam int unsigned SAC_DONE_BIT = 5;
  localparam int unsigned SAC_BUSY_BIT = 4;
  localparam int unsigned SAC_CM_HI = 3;
  localparam int unsigned SAC_CM_LO = 2;
  localparam int unsigned SAC_WIN_BIT = 1;
  localparam int unsigned SAC_LJ_BIT = 0;

  // Timing counts in SAR clocks, the data width and the divider width.
  localparam int unsigned SAC_TRACK_SAR_CLKS = 3;
  localparam int unsigned SAC_RES_BITS = 12;
  localparam int unsigned SAC_DIV_W = 5;

  // Start source encodings of start_source_select.
  typedef enum logic [1:0] {
    SAC_SRC_SW,
    SAC_SRC_T3,
    SAC_SRC_PIN,
    SAC_SRC_T2
  } sac_src_e;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_TRACK,
    SAC_CONV
  } sac_state_e;

endpackage
`default_nettype wire

// File: logic/sac_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module sac_tick_gen #(
  parameter int unsigned DIV_W = 5
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [DIV_W-1:0] div_val,
  output logic tick
);

  logic [DIV_W-1:0] count_reg;
  logic tick_reg;
  wire logic wrap;

  // One tick every div_val plus one system clocks; phase restarts whenever run drops.
  assign wrap = (count_reg == div_val);

  always_ff @(posedge clock) begin
    if (sys_rst || !run) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= wrap ? '0 : count_reg + 1'b1;
      tick_reg <= wrap;
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// File: logic/sac_ctrl.sv
// How it works
// - Enable low holds converter in shutdown.
// - Track mode 0 tracks except converting.
// - Track mode 1 tracking follows start field.
// - Done flag sets at busy fall, sticky.
// - Busy reads one while converting.
// - Busy write starts only in software mode.
// - Start field picks the conversion trigger.
// - Triggered tracking lasts three SAR clocks.
// - Pin mode tracks while pin low.
// - Window match flag sets, software clears.
// - Right justify puts twelve bits low.
// - Right justify upper nibble sign or zero.
// - Left justify, low nibble reads zero.
// - Code is twelve bit unsigned or signed.
// - SAR clock is system clock over divider+1.
// - Differential results are two's complement.
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl #(
  parameter int unsigned RES_BITS = sac_pkg::SAC_RES_BITS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [sac_pkg::SAC_DIV_W-1:0] sar_clock_divider,
  input wire logic input_pair_diff,
  input wire logic timer3_ovf,
  input wire logic timer2_ovf,
  input wire logic ext_convert_start,
  input wire logic sar_cmp,
  input wire logic window_hit,
  output logic conv_powered,
  output logic track_active,
  output logic [RES_BITS-1:0] sar_trial,
  output logic result_strobe,
  output logic [15:0] result_word
);
  import sac_pkg::*;

  // Single-bit mask for a SAR bit position.
  function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = '0;
    bit_mask[idx] = 1'b1;
  endfunction

  sac_state_e state_reg, state_next;
  logic conv_enable_reg, track_mode_select_reg, left_justify_select_reg;
  logic conv_done_flag_reg, window_match_flag_reg;
  sac_src_e start_source_select_reg;
  logic [1:0] track_cnt_reg, track_cnt_next;
  logic [3:0] bit_idx_reg, bit_idx_next;
  logic [RES_BITS-1:0] trial_reg, trial_next;
  logic [7:0] res_hi_reg, res_lo_reg, rdata_reg;
  logic strobe_reg, diff_reg;
  logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
  wire logic sar_tick, ctrl_wr, sw_start, pin_rise, trig, trig_ok, conv_end, busy;
  wire logic kept_bit, use_track;
  wire logic [RES_BITS-1:0] final_raw, code;
  wire logic [7:0] fmt_hi, fmt_lo, ctrl_rd;

  sac_tick_gen #(.DIV_W(SAC_DIV_W)) u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(state_reg != SAC_IDLE),
    .div_val(sar_clock_divider),
    .tick(sar_tick)
  );

  always_ff @(posedge clock) begin
    pin_meta_reg <= ext_convert_start;
    pin_sync_reg <= pin_meta_reg;
    pin_prev_reg <= sys_rst ? 1'b1 : pin_sync_reg;
  end

  // Edge detection only looks at the second and third stages, never the metastable one.
  assign pin_rise = pin_sync_reg && !pin_prev_reg;
  assign ctrl_wr = sfr_wr && (sfr_addr == SAC_CTRL_ADDR);
  assign sw_start = ctrl_wr && sfr_wdata[SAC_BUSY_BIT] && (sfr_wdata[SAC_CM_HI:SAC_CM_LO] == SAC_SRC_SW);
  assign trig = (start_source_select_reg == SAC_SRC_SW) ? sw_start :
                (start_source_select_reg == SAC_SRC_T3) ? timer3_ovf :
                (start_source_select_reg == SAC_SRC_PIN) ? pin_rise : timer2_ovf;
  // triggers dropped unless enabled and idle.
  assign trig_ok = trig && conv_enable_reg && (state_reg == SAC_IDLE);
  // pin mode skips the timed tracking phase.
  assign use_track = track_mode_select_reg && (start_source_select_reg != SAC_SRC_PIN);
  assign busy = (state_reg != SAC_IDLE);
  assign kept_bit = sar_cmp;
  assign conv_end = (state_reg == SAC_CONV) && sar_tick && (bit_idx_reg == 4'd0);

  // Sequencer next state; disabling aborts a conversion without a done flag unless its last SAR clock falls in the first disabled cycle.
  always_comb begin
    state_next = state_reg;
    track_cnt_next = track_cnt_reg;
    bit_idx_next = bit_idx_reg;
    trial_next = trial_reg;
    if (!conv_enable_reg) begin
      state_next = SAC_IDLE;
    end else begin
      unique case (state_reg)
        SAC_IDLE: begin
          if (trig_ok) begin
            track_cnt_next = '0;
            bit_idx_next = 4'(RES_BITS - 1);
            trial_next = bit_mask(4'(RES_BITS - 1));
            state_next = use_track ? SAC_TRACK : SAC_CONV;
          end
        end
        SAC_TRACK: begin
          if (sar_tick) begin
            track_cnt_next = track_cnt_reg + 2'd1;
            if (track_cnt_reg == 2'(SAC_TRACK_SAR_CLKS - 1)) begin
              state_next = SAC_CONV;
            end
          end
        end
        SAC_CONV: begin
          // Successive approximation, one bit per SAR clock, most significant first.
          if (sar_tick) begin
            trial_next = kept_bit ? trial_reg : (trial_reg & ~bit_mask(bit_idx_reg));
            if (bit_idx_reg == 4'd0) begin
              state_next = SAC_IDLE;
            end else begin
              bit_idx_next = bit_idx_reg - 4'd1;
              trial_next = trial_next | bit_mask(bit_idx_reg - 4'd1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= SAC_IDLE;
      track_cnt_reg <= '0;
      bit_idx_reg <= '0;
      trial_reg <= '0;
    end else begin
      state_reg <= state_next;
      track_cnt_reg <= track_cnt_next;
      bit_idx_reg <= bit_idx_next;
      trial_reg <= trial_next;
    end
  end

  // offset binary from the array becomes two's complement for a pair.
  assign final_raw = kept_bit ? trial_reg : (trial_reg & ~bit_mask(4'd0));
  // unsigned twelve-bit or signed eleven-bit-plus-sign code.
  assign code = input_pair_diff ? {~final_raw[RES_BITS-1], final_raw[RES_BITS-2:0]} : final_raw;
  // upper nibble is sign copy for pairs only.
  // left-justified layout with zero low nibble.
  assign fmt_hi = left_justify_select_reg ? code[11:4] : {{4{input_pair_diff & code[11]}}, code[11:8]};
  assign fmt_lo = left_justify_select_reg ? {code[3:0], 4'h0} : code[7:0];

  // Control register and result bytes; hardware updates win over a same-cycle write.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {conv_enable_reg, track_mode_select_reg, conv_done_flag_reg} <= SAC_CTRL_RST[7:5];
      start_source_select_reg <= sac_src_e'(SAC_CTRL_RST[3:2]);
      {window_match_flag_reg, left_justify_select_reg} <= SAC_CTRL_RST[1:0];
      res_hi_reg <= SAC_RES_RST;
      res_lo_reg <= SAC_RES_RST;
      strobe_reg <= 1'b0;
      diff_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        conv_enable_reg <= sfr_wdata[SAC_EN_BIT];
        track_mode_select_reg <= sfr_wdata[SAC_TM_BIT];
        start_source_select_reg <= sac_src_e'(sfr_wdata[SAC_CM_HI:SAC_CM_LO]);
        left_justify_select_reg <= sfr_wdata[SAC_LJ_BIT];
      end
      // done flag set wins over clear.
      conv_done_flag_reg <= conv_end | (ctrl_wr ? sfr_wdata[SAC_DONE_BIT] : conv_done_flag_reg);
      // window flag set wins over clear.
      window_match_flag_reg <= (strobe_reg & window_hit) |
                               (ctrl_wr ? sfr_wdata[SAC_WIN_BIT] : window_match_flag_reg);
      res_hi_reg <= conv_end ? fmt_hi : (sfr_wr && sfr_addr == SAC_RES_HI_ADDR) ? sfr_wdata : res_hi_reg;
      res_lo_reg <= conv_end ? fmt_lo : (sfr_wr && sfr_addr == SAC_RES_LO_ADDR) ? sfr_wdata : res_lo_reg;
      strobe_reg <= conv_end;
      diff_reg <= input_pair_diff;
    end
  end

  // busy read back from the sequencer state.
  assign ctrl_rd = {conv_enable_reg, track_mode_select_reg, conv_done_flag_reg, busy,
                    start_source_select_reg, window_match_flag_reg, left_justify_select_reg};

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      rdata_reg <= (sfr_addr == SAC_CTRL_ADDR) ? ctrl_rd :
                   (sfr_addr == SAC_RES_HI_ADDR) ? res_hi_reg :
                   (sfr_addr == SAC_RES_LO_ADDR) ? res_lo_reg : 8'h00;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign conv_powered = conv_enable_reg;
  // continuous tracking; gated tracking in mode 1.
  assign track_active = conv_enable_reg && (track_mode_select_reg ?
    ((state_reg == SAC_TRACK) || (start_source_select_reg == SAC_SRC_PIN && !busy && !pin_sync_reg)) :
    (state_reg != SAC_CONV));
  assign sar_trial = trial_reg;
  assign result_strobe = strobe_reg;
  assign result_word = {res_hi_reg, res_lo_reg};

  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [3:0] trk_len_reg;
  always_ff @(posedge clock) begin
    if (sys_rst || state_reg != SAC_TRACK) begin
      trk_len_reg <= '0;
    end else if (sar_tick) begin
      trk_len_reg <= trk_len_reg + 4'd1;
    end
  end

  shutdown_idle_a: assert property (!conv_enable_reg |=> state_reg == SAC_IDLE)
    else $error("Converter active while disabled.");
  cont_track_a: assert property (conv_enable_reg && !track_mode_select_reg && state_reg == SAC_IDLE |-> track_active)
    else $error("No continuous tracking while idle.");
  gated_track_a: assert property (track_mode_select_reg && start_source_select_reg != SAC_SRC_PIN
    && state_reg == SAC_IDLE |-> !track_active)
    else $error("Tracking outside timed phase.");
  done_set_a: assert property (conv_end |=> conv_done_flag_reg && $fell(busy))
    else $error("Done flag missed at busy fall.");
  busy_read_a: assert property (sfr_rd && sfr_addr == SAC_CTRL_ADDR
    |=> sfr_rdata[SAC_BUSY_BIT] == $past(busy))
    else $error("Busy bit disagrees with state.");
  sw_gate_a: assert property (state_reg == SAC_IDLE && start_source_select_reg != SAC_SRC_SW
    && !timer2_ovf && !timer3_ovf && !pin_rise |=> state_reg == SAC_IDLE)
    else $error("Start without a selected trigger.");
  sw_start_a: assert property (conv_enable_reg && state_reg == SAC_IDLE
    && start_source_select_reg == SAC_SRC_SW && sw_start |=> busy)
    else $error("Software start not taken.");
  busy_zero_a: assert property (ctrl_wr && !sfr_wdata[SAC_BUSY_BIT] && state_reg == SAC_IDLE
    && start_source_select_reg == SAC_SRC_SW |=> !busy)
    else $error("Busy write of zero started a conversion.");
  t3_start_a: assert property (conv_enable_reg && state_reg == SAC_IDLE && start_source_select_reg == SAC_SRC_T3
    && timer3_ovf |=> state_reg != SAC_IDLE)
    else $error("Timer 3 overflow did not start.");
  track_len_a: assert property (state_reg == SAC_TRACK && state_next == SAC_CONV
    |-> trk_len_reg == 4'(SAC_TRACK_SAR_CLKS - 1) && sar_tick)
    else $error("Tracking phase not three SAR clocks.");
  pin_track_a: assert property (conv_enable_reg && track_mode_select_reg && start_source_select_reg == SAC_SRC_PIN
    && !busy |-> track_active == !pin_sync_reg)
    else $error("Pin mode tracking wrong.");
  win_set_a: assert property (result_strobe && window_hit |=> window_match_flag_reg)
    else $error("Window flag not set.");
  left_zero_a: assert property (conv_end && left_justify_select_reg |=> res_lo_reg[3:0] == 4'h0)
    else $error("Left-justified low nibble not zero.");
  right_top_a: assert property (conv_end && !left_justify_select_reg && !diff_reg && !input_pair_diff
    |=> res_hi_reg[7:4] == 4'h0)
    else $error("Single-ended upper nibble not zero.");

  cov_sw_conv: cover property (sw_start && trig_ok ##[1:800] conv_end);
  cov_timed_track: cover property (state_reg == SAC_TRACK ##[1:200] state_reg == SAC_CONV);
  cov_pin_start: cover property (pin_rise && trig_ok);
  cov_window: cover property (result_strobe && window_hit);

endmodule
`default_nettype wire

// File: verif/sac_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// Far side of the converter: two timers, the start pin, an ideal array and a window detector.
module sac_far_side (
  input wire logic clock,
  input wire logic [11:0] sar_trial,
  input wire logic [15:0] result_word,
  output logic sar_cmp,
  output var logic timer3_ovf,
  output var logic timer2_ovf,
  output var logic ext_convert_start,
  output logic window_hit
);
  logic [11:0] raw_code = 12'h0000;
  logic [15:0] win_lim = 16'h0000;

  // The ideal array keeps a trial bit while the held input is at or above the trial code.
  assign sar_cmp = (sar_trial <= raw_code);
  // The detector flags results below the limit; it is only looked at during the strobe.
  assign window_hit = (result_word < win_lim);

  // The pin idles high, as if pulled up.
  initial begin
    timer3_ovf = 1'b0;
    timer2_ovf = 1'b0;
    ext_convert_start = 1'b1;
  end

  // An overflow lasts one clock, launched just after a falling edge.
  task automatic ovf(input logic t2);
    @(negedge clock);
    if (t2) begin
      timer2_ovf = 1'b1;
    end else begin
      timer3_ovf = 1'b1;
    end
    @(negedge clock);
    timer2_ovf = 1'b0;
    timer3_ovf = 1'b0;
  endtask

  // The pin is moved off the sampling edge; it is synchronised inside the block.
  task automatic pin_to(input logic v);
    @(negedge clock);
    ext_convert_start = v;
  endtask
endmodule
`default_nettype wire

// File: verif/sac_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl_tb;
  import sac_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [4:0] div = 5'h00;
  logic diff = 1'b0;
  logic [7:0] sfr_rdata;
  logic t3, t2, pin, cmp, win, powered, track, strobe;
  logic [11:0] trial;
  logic [15:0] word;
  logic [15:0] exp_q[$];
  int lat_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int stamp = 0;
  int rcount = 0;
  int lat_now;

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  sac_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sar_clock_divider(div), .input_pair_diff(diff),
    .timer3_ovf(t3), .timer2_ovf(t2), .ext_convert_start(pin), .sar_cmp(cmp), .window_hit(win),
    .conv_powered(powered), .track_active(track), .sar_trial(trial), .result_strobe(strobe),
    .result_word(word));
  sac_far_side part (.clock(clock), .sar_trial(trial), .result_word(word), .sar_cmp(cmp),
    .timer3_ovf(t3), .timer2_ovf(t2), .ext_convert_start(pin), .window_hit(win));

  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    samples_checked++;
    if (got !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask

  // Read data is registered, so it is settled by the falling edge after the read.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    chk(what, {8'h00, e}, {8'h00, sfr_rdata});
  endtask

  // One conversion: set up, note the expected word and latency, trigger, then check flags.
  task automatic conv(input logic [1:0] src, input logic tm, input logic lj, input logic dif);
    logic [11:0] v;
    logic [15:0] e;
    logic [7:0] cfg;
    int n, r0;
    v = 12'($urandom);
    div = 5'($urandom % 4);
    diff = dif;
    part.raw_code = dif ? v ^ 12'h800 : v;
    part.win_lim = 16'($urandom);
    e = lj ? {v, 4'h0} : {{4{v[11] & dif}}, v};
    n = (tm && src != SAC_SRC_PIN) ? 15 : 12;
    cfg = {1'b1, tm, 2'b00, src, 1'b0, lj};
    wr(SAC_CTRL_ADDR, cfg);
    if (src == SAC_SRC_PIN) begin
      part.pin_to(1'b0);
      repeat (4) @(negedge clock);
    end
    chk("idle tracking", 16'(tm ? src == SAC_SRC_PIN : 1'b1), 16'(track));
    exp_q.push_back(e);
    lat_q.push_back(src == SAC_SRC_PIN ? -1 : 1 + n * (div + 1));
    r0 = rcount;
    case (src)
      SAC_SRC_SW: wr(SAC_CTRL_ADDR, cfg | 8'h10);
      SAC_SRC_PIN: part.pin_to(1'b1);
      default: part.ovf(src[1]);
    endcase
    stamp = cyc;
    if (src == SAC_SRC_PIN) repeat (4) @(negedge clock);
    chk("busy tracking", 16'(tm && src != SAC_SRC_PIN), 16'(track));
    // A second overflow during the conversion must not queue another one.
    if (src[0]) part.ovf(src[1]);
    rd(SAC_CTRL_ADDR, cfg | 8'h10, "busy status");
    for (int i = 0; i < 400 && rcount == r0; i++) @(negedge clock);
    if (rcount == r0) begin
      chk("conversion finished", 16'h0001, 16'h0000);
      results();
    end
    rd(SAC_CTRL_ADDR, cfg | 8'h20 | {6'h00, e < part.win_lim, 1'b0}, "flags");
    wr(SAC_CTRL_ADDR, cfg);
    rd(SAC_CTRL_ADDR, cfg, "flags cleared");
  endtask

  // Each result strobe takes the oldest expectation off the queue.
  always @(negedge clock) begin
    if (strobe === 1'b1) begin
      rcount++;
      chk("result queued", 16'h0001, 16'(exp_q.size() != 0));
      if (exp_q.size() != 0) begin
        lat_now = lat_q.pop_front();
        chk("result word", exp_q.pop_front(), word);
        if (lat_now >= 0) chk("latency", 16'(lat_now), 16'(cyc - stamp));
      end
    end
  end

  initial begin
    void'($urandom(60313));
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    rd(SAC_CTRL_ADDR, SAC_CTRL_RST, "control reset");
    rd(SAC_RES_LO_ADDR, SAC_RES_RST, "low byte reset");
    rd(SAC_RES_HI_ADDR, SAC_RES_RST, "high byte reset");
    rd(8'h00, 8'h00, "unmapped read");
    wr(SAC_RES_LO_ADDR, 8'h5a);
    wr(SAC_RES_HI_ADDR, 8'ha5);
    rd(SAC_RES_LO_ADDR, 8'h5a, "low byte write");
    rd(SAC_RES_HI_ADDR, 8'ha5, "high byte write");
    // Disabled, a timer overflow is lost; enabled, a busy write outside mode 00 is lost.
    wr(SAC_CTRL_ADDR, 8'h04);
    chk("powered off", 16'h0000, 16'(powered));
    chk("off tracking", 16'h0000, 16'(track));
    part.ovf(1'b0);
    wr(SAC_CTRL_ADDR, 8'h84);
    wr(SAC_CTRL_ADDR, 8'h94);
    repeat (80) @(negedge clock);
    chk("powered on", 16'h0001, 16'(powered));
    rd(SAC_CTRL_ADDR, 8'h84, "no start");
    for (int i = 0; i < 32; i++) conv(2'(i), i[2], i[3], i[4]);
    chk("pending results", 16'h0000, 16'(exp_q.size()));
    results();
  end
endmodule
`default_nettype wire
